// >>> common/crf_pkg.sv
package crf_pkg;

  localparam int unsigned CRF_DATA_W = 32;
  localparam int unsigned CRF_NUM_REGS = 16;
  localparam int unsigned CRF_IDX_W = 4;

  // register indices
  localparam logic [3:0] CRF_IDX_GP_FIRST = 4'h0;
  localparam logic [3:0] CRF_IDX_GP_LAST = 4'h8;
  localparam logic [3:0] CRF_IDX_STR0 = 4'h0;
  localparam logic [3:0] CRF_IDX_STR1 = 4'h1;
  localparam logic [3:0] CRF_IDX_STR2 = 4'h2;
  localparam logic [3:0] CRF_IDX_FRAME_POINTER = 4'h9;
  localparam logic [3:0] CRF_IDX_ARGUMENT_POINTER = 4'ha;
  localparam logic [3:0] CRF_IDX_PROCESSOR_STATUS_WORD = 4'hb;
  localparam logic [3:0] CRF_IDX_STACK_POINTER = 4'hc;
  localparam logic [3:0] CRF_IDX_PROCESS_CONTEXT_BLOCK_POINTER = 4'hd;
  localparam logic [3:0] CRF_IDX_INTERRUPT_STACK_POINTER = 4'he;
  localparam logic [3:0] CRF_IDX_PROGRAM_COUNTER = 4'hf;
  localparam int unsigned CRF_NUM_GPR_ARRAY = 11;

  // execution privilege levels
  typedef enum logic [1:0] {
    CRF_LVL_KERNEL = 2'h0,
    CRF_LVL_EXECUTIVE = 2'h1,
    CRF_LVL_SUPERVISOR = 2'h2,
    CRF_LVL_USER = 2'h3
  } crf_level_e;

  // stack operand size codes
  typedef enum logic [1:0] {
    CRF_SZ_BYTE = 2'h0,
    CRF_SZ_HALF = 2'h1,
    CRF_SZ_WORD = 2'h2
  } crf_size_e;
  localparam logic [31:0] CRF_BYTES_BYTE = 32'h0000_0001;
  localparam logic [31:0] CRF_BYTES_HALF = 32'h0000_0002;
  localparam logic [31:0] CRF_BYTES_WORD = 32'h0000_0004;

  // condition flag field inside the status word
  localparam int unsigned CRF_PSW_FLAG_LSB = 18;
  localparam int unsigned CRF_PSW_FLAG_W = 4;

  // reset values
  localparam logic [31:0] CRF_RST_GPR = 32'h0000_0000;
  localparam logic [31:0] CRF_RST_PSW = 32'h0000_0000;
  localparam logic [31:0] CRF_RST_SP = 32'h0000_0000;
  localparam logic [31:0] CRF_RST_PROCESS_CONTEXT_BLOCK_POINTER = 32'h0000_0000;
  localparam logic [31:0] CRF_RST_ISP = 32'h0000_0000;
  localparam logic [31:0] CRF_RST_PC = 32'h0000_0000;

  function automatic logic crf_is_privileged(input logic [3:0] idx);
    return (idx == CRF_IDX_PROCESSOR_STATUS_WORD) ||
           (idx == CRF_IDX_PROCESS_CONTEXT_BLOCK_POINTER) ||
           (idx == CRF_IDX_INTERRUPT_STACK_POINTER);
  endfunction

endpackage

// >>> hdl/crf_priv_check.sv
module crf_priv_check
  import crf_pkg::*;
(
  // explicit write request
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire crf_pkg::crf_level_e exec_level,
  // verdict
  output logic wr_ok,
  output logic wr_fault
);
  logic priv_target;
  logic in_kernel;

  always_comb begin
    priv_target = crf_is_privileged(wr_idx);
    in_kernel = (exec_level == CRF_LVL_KERNEL);
    // RULE3 RULE4
    wr_ok = wr_en && (!priv_target || in_kernel);
    // RULE17
    wr_fault = wr_en && priv_target && !in_kernel;
  end

endmodule

// >>> hdl/crf_stack_unit.sv
module crf_stack_unit
  import crf_pkg::*;
(
  // stack pointer and requests
  input wire logic [31:0] sp_cur,
  input wire logic push,
  input wire logic pop,
  input wire crf_pkg::crf_size_e size,
  // results
  output logic [31:0] sp_next,
  output logic [31:0] mem_addr
);
  logic [31:0] nbytes;

  always_comb begin
    case (size)
      CRF_SZ_BYTE: nbytes = CRF_BYTES_BYTE;
      CRF_SZ_HALF: nbytes = CRF_BYTES_HALF;
      default: nbytes = CRF_BYTES_WORD;
    endcase
    sp_next = sp_cur;
    mem_addr = sp_cur;
    if (push) begin
      // store at old pointer, then grow upward
      mem_addr = sp_cur; // RULE9
      sp_next = sp_cur + nbytes; // RULE9
    end else if (pop) begin
      // shrink first, then read at the new pointer
      sp_next = sp_cur - nbytes; // RULE10
      mem_addr = sp_cur - nbytes; // RULE10
    end
  end

endmodule

// >>> hdl/crf_regfile.sv
// How it works
// RULE1 - sixteen 32-bit registers; 0-8 general, 9-15 special purpose.
// RULE2 - every register except 11 and 15 serves in any addressing mode.
// RULE3 - registers 11, 13, 14 always readable, written only in kernel mode.
// RULE4 - other registers read and written at all four privilege levels.
// RULE5 - status word holds four condition flags used by control transfers.
// RULE6 - registers 0-8 selectable by all arithmetic, transfer, logic, control ops.
// RULE7 - block move and string ops implicitly use registers 0, 1, 2.
// RULE8 - register 12 holds address of next free stack location.
// RULE9 - push stores at stack pointer, then increments it by operand size.
// RULE10 - pop decrements stack pointer by size, then reads that item.
// RULE11 - register 15 holds current instruction address, then the next one.
// RULE12 - register 9 changed implicitly by register save and restore.
// RULE13 - register 10 changed implicitly by procedure call and return.
// RULE14 - status word replaced whole only on process switch; else fields only. Here a kernel write to register 11 also replaces it whole.
// RULE15 - register 13 holds start address of current process context block.
// RULE16 - register 14 holds top of interrupt stack.
// RULE17 - privileged write outside kernel is dropped and raises an exception.
module crf_regfile
  import crf_pkg::*;
#(
  parameter int unsigned DATA_W = CRF_DATA_W
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // privilege
  input wire crf_pkg::crf_level_e exec_level,
  // read port a
  input wire logic rd_a_en,
  input wire logic [3:0] rd_a_idx,
  output logic [DATA_W-1:0] rd_a_data,
  output logic rd_a_valid,
  // read port b
  input wire logic rd_b_en,
  input wire logic [3:0] rd_b_idx,
  output logic [DATA_W-1:0] rd_b_data,
  output logic rd_b_valid,
  // operand mode check
  input wire logic [3:0] opnd_idx,
  input wire logic opnd_mode_check,
  output logic opnd_illegal,
  // explicit write
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [DATA_W-1:0] wr_data,
  output logic priv_fault,
  // string and block move working registers
  input wire logic [2:0] str_wr_en,
  input wire logic [DATA_W-1:0] str_wr_data0,
  input wire logic [DATA_W-1:0] str_wr_data1,
  input wire logic [DATA_W-1:0] str_wr_data2,
  // frame and argument pointers
  input wire logic frame_pointer_load,
  input wire logic [DATA_W-1:0] frame_pointer_value,
  input wire logic argument_pointer_load,
  input wire logic [DATA_W-1:0] argument_pointer_value,
  // status word
  input wire logic flags_we,
  input wire logic [3:0] flags_in,
  input wire logic psw_switch_load,
  input wire logic [DATA_W-1:0] psw_switch_value,
  output logic [3:0] cond_flags,
  // stack
  input wire logic push_req,
  input wire logic pop_req,
  input wire crf_pkg::crf_size_e stack_size,
  output logic [DATA_W-1:0] stack_mem_addr,
  output logic stack_mem_valid,
  output logic [DATA_W-1:0] stack_pointer_out,
  // process switch and interrupt stack
  input wire logic process_context_block_pointer_switch_load,
  input wire logic [DATA_W-1:0] process_context_block_pointer_switch_value,
  input wire logic isp_load,
  input wire logic [DATA_W-1:0] isp_value,
  // program counter
  input wire logic pc_load,
  input wire logic [DATA_W-1:0] pc_target,
  input wire logic pc_advance,
  input wire logic [DATA_W-1:0] pc_length,
  output logic [DATA_W-1:0] program_counter_out
);
  import crf_pkg::*;

  if (DATA_W != CRF_DATA_W) begin : g_width_check
    $error("crf_regfile: DATA_W must equal the 32-bit register width");
  end

  logic [DATA_W-1:0] gpr_q [0:CRF_NUM_GPR_ARRAY-1];
  logic [DATA_W-1:0] psw_q;
  logic [DATA_W-1:0] sp_q;
  logic [DATA_W-1:0] process_context_block_pointer_q;
  logic [DATA_W-1:0] isp_q;
  logic [DATA_W-1:0] pc_q;
  logic [DATA_W-1:0] rd_a_q;
  logic [DATA_W-1:0] rd_b_q;
  logic rd_a_valid_q;
  logic rd_b_valid_q;
  logic priv_fault_q;
  logic [DATA_W-1:0] stack_addr_q;
  logic stack_valid_q;
  logic wr_ok;
  logic wr_fault;
  logic [DATA_W-1:0] sp_next;
  logic [DATA_W-1:0] stack_addr_d;
  logic pop_eff;

  // a push and a pop in one cycle cannot both be honoured; push is kept
  assign pop_eff = pop_req && !push_req;

  crf_priv_check u_priv (
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .exec_level(exec_level),
    .wr_ok(wr_ok),
    .wr_fault(wr_fault)
  );

  crf_stack_unit u_stack (
    .sp_cur(sp_q),
    .push(push_req),
    .pop(pop_eff),
    .size(stack_size),
    .sp_next(sp_next),
    .mem_addr(stack_addr_d)
  );

  function automatic logic wr_hit(input logic ok, input logic [3:0] idx,
                                  input logic [3:0] target);
    return ok && (idx == target);
  endfunction

  function automatic logic [DATA_W-1:0] rd_sel(input logic [3:0] idx);
    logic [DATA_W-1:0] v;
    v = '0;
    if (idx == CRF_IDX_PROCESSOR_STATUS_WORD) begin
      v = psw_q;
    end else if (idx == CRF_IDX_STACK_POINTER) begin
      v = sp_q;
    end else if (idx == CRF_IDX_PROCESS_CONTEXT_BLOCK_POINTER) begin
      v = process_context_block_pointer_q;
    end else if (idx == CRF_IDX_INTERRUPT_STACK_POINTER) begin
      v = isp_q;
    end else if (idx == CRF_IDX_PROGRAM_COUNTER) begin
      v = pc_q;
    end else begin
      v = gpr_q[idx];
    end
    return v;
  endfunction

  // registers 0 to 10; implicit updates win over an explicit write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < CRF_NUM_GPR_ARRAY; i++) begin
        gpr_q[i] <= CRF_RST_GPR; // RULE1
      end
    end else begin
      for (int i = 0; i < CRF_NUM_GPR_ARRAY; i++) begin
        if (wr_hit(wr_ok, wr_idx, 4'(i))) begin
          gpr_q[i] <= wr_data; // RULE4 RULE6
        end
      end
      if (str_wr_en[0]) begin
        gpr_q[CRF_IDX_STR0] <= str_wr_data0; // RULE7
      end
      if (str_wr_en[1]) begin
        gpr_q[CRF_IDX_STR1] <= str_wr_data1; // RULE7
      end
      if (str_wr_en[2]) begin
        gpr_q[CRF_IDX_STR2] <= str_wr_data2; // RULE7
      end
      if (frame_pointer_load) begin
        gpr_q[CRF_IDX_FRAME_POINTER] <= frame_pointer_value; // RULE12
      end
      if (argument_pointer_load) begin
        gpr_q[CRF_IDX_ARGUMENT_POINTER] <= argument_pointer_value; // RULE13
      end
    end
  end

  // status word: whole replacement only by process switch or kernel write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      psw_q <= CRF_RST_PSW;
    end else if (psw_switch_load) begin
      psw_q <= psw_switch_value; // RULE14
    end else begin
      if (wr_hit(wr_ok, wr_idx, CRF_IDX_PROCESSOR_STATUS_WORD)) begin
        psw_q <= wr_data; // RULE3
      end
      if (flags_we) begin
        // only the flag field moves; a same-cycle kernel write keeps the rest
        psw_q[CRF_PSW_FLAG_LSB +: CRF_PSW_FLAG_W] <= flags_in; // RULE5 RULE14
      end
    end
  end

  // stack pointer: push and pop take priority over an explicit write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sp_q <= CRF_RST_SP;
    end else if (push_req || pop_eff) begin
      sp_q <= sp_next; // RULE8 RULE9 RULE10
    end else if (wr_hit(wr_ok, wr_idx, CRF_IDX_STACK_POINTER)) begin
      sp_q <= wr_data; // RULE8
    end
  end

  // memory address for the stack access, one cycle after the request
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stack_addr_q <= '0;
      stack_valid_q <= 1'b0;
    end else begin
      stack_valid_q <= push_req || pop_eff;
      if (push_req || pop_eff) begin
        stack_addr_q <= stack_addr_d; // RULE9 RULE10
      end
    end
  end

  // context block pointer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      process_context_block_pointer_q <= CRF_RST_PROCESS_CONTEXT_BLOCK_POINTER;
    end else if (process_context_block_pointer_switch_load) begin
      process_context_block_pointer_q <= process_context_block_pointer_switch_value; // RULE15
    end else if (wr_hit(wr_ok, wr_idx, CRF_IDX_PROCESS_CONTEXT_BLOCK_POINTER)) begin
      process_context_block_pointer_q <= wr_data; // RULE3 RULE15
    end
  end

  // interrupt stack pointer; the microsequence load is not privilege checked
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      isp_q <= CRF_RST_ISP;
    end else if (isp_load) begin
      isp_q <= isp_value; // RULE16
    end else if (wr_hit(wr_ok, wr_idx, CRF_IDX_INTERRUPT_STACK_POINTER)) begin
      isp_q <= wr_data; // RULE3 RULE16
    end
  end

  // program counter: branch target beats an explicit write beats advance
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_q <= CRF_RST_PC;
    end else if (pc_load) begin
      pc_q <= pc_target; // RULE11
    end else if (wr_hit(wr_ok, wr_idx, CRF_IDX_PROGRAM_COUNTER)) begin
      pc_q <= wr_data; // RULE11
    end else if (pc_advance) begin
      pc_q <= pc_q + pc_length; // RULE11
    end
  end

  // reads show the value before any same-cycle write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_a_q <= '0;
      rd_b_q <= '0;
      rd_a_valid_q <= 1'b0;
      rd_b_valid_q <= 1'b0;
    end else begin
      rd_a_valid_q <= rd_a_en;
      rd_b_valid_q <= rd_b_en;
      if (rd_a_en) begin
        rd_a_q <= rd_sel(rd_a_idx); // RULE3 RULE4
      end
      if (rd_b_en) begin
        rd_b_q <= rd_sel(rd_b_idx); // RULE3 RULE4
      end
    end
  end

  // one-cycle exception pulse toward the exception logic
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      priv_fault_q <= 1'b0;
    end else begin
      priv_fault_q <= wr_fault; // RULE17
    end
  end

  // status word and program counter cannot serve as general operands
  assign opnd_illegal = opnd_mode_check &&
                        ((opnd_idx == CRF_IDX_PROCESSOR_STATUS_WORD) ||
                         (opnd_idx == CRF_IDX_PROGRAM_COUNTER)); // RULE2

  assign rd_a_data = rd_a_q;
  assign rd_b_data = rd_b_q;
  assign rd_a_valid = rd_a_valid_q;
  assign rd_b_valid = rd_b_valid_q;
  assign priv_fault = priv_fault_q;
  assign cond_flags = psw_q[CRF_PSW_FLAG_LSB +: CRF_PSW_FLAG_W]; // RULE5
  assign stack_mem_addr = stack_addr_q;
  assign stack_mem_valid = stack_valid_q;
  assign stack_pointer_out = sp_q;
  assign program_counter_out = pc_q;

endmodule

// >>> verification/crf_regfile_sva.sv
module crf_regfile_sva
  import crf_pkg::*;
#(
  parameter int unsigned DATA_W = CRF_DATA_W
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // requests
  input wire crf_pkg::crf_level_e exec_level,
  input wire logic rd_a_en,
  input wire logic rd_b_en,
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [3:0] opnd_idx,
  input wire logic opnd_mode_check,
  input wire logic flags_we,
  input wire logic [3:0] flags_in,
  input wire logic psw_switch_load,
  input wire logic push_req,
  input wire logic pop_req,
  input wire crf_pkg::crf_size_e stack_size,
  input wire logic pc_load,
  input wire logic pc_advance,
  input wire logic [DATA_W-1:0] pc_length,
  // results
  input wire logic rd_a_valid,
  input wire logic rd_b_valid,
  input wire logic opnd_illegal,
  input wire logic priv_fault,
  input wire logic [3:0] cond_flags,
  input wire logic [DATA_W-1:0] stack_mem_addr,
  input wire logic stack_mem_valid,
  input wire logic [DATA_W-1:0] stack_pointer_out,
  input wire logic [DATA_W-1:0] program_counter_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic priv_idx;
  logic refuse;
  logic [DATA_W-1:0] step;
  assign priv_idx = (wr_idx == CRF_IDX_PROCESSOR_STATUS_WORD) ||
    (wr_idx == CRF_IDX_PROCESS_CONTEXT_BLOCK_POINTER) ||
    (wr_idx == CRF_IDX_INTERRUPT_STACK_POINTER);
  assign refuse = wr_en && priv_idx && (exec_level != CRF_LVL_KERNEL);
  // code 3 is not defined, so it counts as a word
  assign step = (stack_size == CRF_SZ_BYTE) ? DATA_W'(1) : (stack_size == CRF_SZ_HALF) ?
    DATA_W'(2) : DATA_W'(4);
  a_rd_a_answer: assert property (rd_a_en |=> rd_a_valid) else $error("read a late");
  a_rd_b_pulse: assert property (!rd_b_en |=> !rd_b_valid) else $error("read b extra");
  a_priv_refused: assert property (refuse |=> priv_fault) else $error("no fault");
  a_fault_cause: assert property (priv_fault |-> $past(refuse)) else $error("bad fault");
  a_kernel_ok: assert property (wr_en && exec_level == CRF_LVL_KERNEL |=> !priv_fault)
    else $error("kernel write faulted");
  a_push_order: assert property (push_req |=> stack_mem_valid &&
    stack_mem_addr == $past(stack_pointer_out) &&
    stack_pointer_out == $past(stack_pointer_out) + $past(step)) else $error("push wrong");
  a_pop_order: assert property (pop_req && !push_req |=> stack_mem_valid &&
    stack_pointer_out == $past(stack_pointer_out) - $past(step) &&
    stack_mem_addr == stack_pointer_out) else $error("pop wrong");
  a_opnd_mode: assert property (opnd_illegal == (opnd_mode_check &&
    (opnd_idx == CRF_IDX_PROCESSOR_STATUS_WORD || opnd_idx == CRF_IDX_PROGRAM_COUNTER)))
    else $error("operand check wrong");
  a_flag_field: assert property (flags_we && !psw_switch_load |=>
    cond_flags == $past(flags_in)) else $error("flags wrong");
  a_pc_step: assert property (pc_advance && !pc_load && !(wr_en &&
    wr_idx == CRF_IDX_PROGRAM_COUNTER) |=> program_counter_out ==
    $past(program_counter_out) + $past(pc_length)) else $error("pc advance wrong");
  c_push: cover property (push_req ##1 pop_req);
  c_fault: cover property (priv_fault);
  c_pc: cover property (pc_advance);
endmodule

bind crf_regfile crf_regfile_sva #(.DATA_W(DATA_W)) u_sva (.*);

// >>> verification/testbench.sv
module testbench
  import crf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_b = 0, rd_a_en = 0, rd_b_en = 0, opnd_mode_check = 0, wr_en = 0;
  logic frame_pointer_load = 0, argument_pointer_load = 0, flags_we = 0, psw_switch_load = 0;
  logic push_req = 0, pop_req = 0, process_context_block_pointer_switch_load = 0, isp_load = 0, pc_load = 0;
  logic pc_advance = 0;
  logic [3:0] rd_a_idx = 0, rd_b_idx = 0, opnd_idx = 0, wr_idx = 0, flags_in = 0;
  logic [2:0] str_wr_en = 0;
  logic [31:0] wr_data = 0, str_wr_data0 = 0, str_wr_data1 = 0, str_wr_data2 = 0;
  logic [31:0] frame_pointer_value = 0, argument_pointer_value = 0, psw_switch_value = 0;
  logic [31:0] process_context_block_pointer_switch_value = 0, isp_value = 0, pc_target = 0, pc_length = 0;
  crf_level_e exec_level = CRF_LVL_KERNEL;
  crf_size_e stack_size = CRF_SZ_BYTE;
  logic [31:0] rd_a_data, rd_b_data, stack_mem_addr, stack_pointer_out, program_counter_out;
  logic rd_a_valid, rd_b_valid, opnd_illegal, priv_fault, stack_mem_valid;
  logic [3:0] cond_flags;
  int failures = 0;
  int comparisons = 0;
  logic [31:0] m [16];
  logic [31:0] qa [$];
  logic [31:0] qb [$];
  logic [31:0] qsa [$];
  logic [31:0] qsp [$];
  logic [15:0] seed = 16'h4e98;

  always #2.5 clk = ~clk;

  crf_regfile dut (.*);

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return {seed, ~seed};
  endfunction

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  // both ports every cycle, b walking the opposite end to catch crossed selects
  task automatic rd_all();
    for (int i = 0; i < 16; i++) begin
      rd_a_en = 1;
      rd_b_en = 1;
      rd_a_idx = 4'(i);
      rd_b_idx = ~4'(i);
      qa.push_back(m[i]);
      qb.push_back(m[15 - i]);
      tick();
    end
    rd_a_en = 0;
    rd_b_en = 0;
    tick();
  endtask

  task automatic wr(input logic [3:0] i, input logic [1:0] lv);
    logic bad;
    bad = (lv != 2'h0) && (i == 4'hb || i == 4'hd || i == 4'he);
    exec_level = crf_level_e'(lv);
    wr_en = 1;
    wr_idx = i;
    wr_data = rnd();
    tick();
    check("priv_fault", {31'h0, priv_fault}, {31'h0, bad});
    if (!bad) m[i] = wr_data;
  endtask

  // both strobes at once must behave as a lone push
  task automatic stk(input logic up, input logic dn, input int s);
    logic [31:0] b;
    logic [31:0] sp;
    b = (s == 0) ? 32'h1 : (s == 1) ? 32'h2 : 32'h4;
    sp = m[12];
    push_req = up;
    pop_req = dn;
    stack_size = crf_size_e'(s);
    m[12] = up ? sp + b : sp - b;
    qsa.push_back(up ? sp : m[12]);
    qsp.push_back(m[12]);
    tick();
  endtask

  task automatic finish_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(negedge clk) begin
    if (rd_a_valid === 1'b1) check("rd_a_data", rd_a_data, qa.pop_front());
    if (rd_b_valid === 1'b1) check("rd_b_data", rd_b_data, qb.pop_front());
    if (stack_mem_valid === 1'b1) begin
      check("stack_mem_addr", stack_mem_addr, qsa.pop_front());
      check("stack_pointer_out", stack_pointer_out, qsp.pop_front());
    end
  end

  initial begin
    #10000;
    failures++;
    finish_test();
  end

  initial begin
    for (int i = 0; i < 16; i++) m[i] = 32'h0;
    repeat (3) @(posedge clk);
    #1 rst_b = 1;
    rd_all();
    for (int lv = 0; lv < 4; lv++) begin
      for (int i = 0; i < 16; i++) wr(4'(i), 2'(lv));
      wr_en = 0;
      rd_all();
    end
    opnd_mode_check = 1;
    for (int i = 0; i < 16; i++) begin
      opnd_idx = 4'(i);
      tick();
      check("opnd_illegal", {31'h0, opnd_illegal}, {31'h0, i == 11 || i == 15});
    end
    opnd_mode_check = 0;
    wr(4'hc, 2'h0);
    wr_en = 0;
    for (int s = 0; s < 4; s++) stk(1'b1, 1'b0, s);
    for (int s = 3; s >= 0; s--) stk(1'b0, 1'b1, s);
    stk(1'b1, 1'b1, 2);
    {push_req, pop_req} = 2'h0;
    // sequencer loads bypass the privilege check, so run them from user level
    exec_level = CRF_LVL_USER;
    str_wr_en = 3'h7;
    {frame_pointer_load, argument_pointer_load, process_context_block_pointer_switch_load, isp_load} = 4'hf;
    {psw_switch_load, pc_load} = 2'h3;
    {str_wr_data0, str_wr_data1, str_wr_data2, frame_pointer_value} = {rnd(), rnd(), rnd(), rnd()};
    {argument_pointer_value, psw_switch_value, process_context_block_pointer_switch_value} = {rnd(), rnd(), rnd()};
    {isp_value, pc_target} = {rnd(), rnd()};
    tick();
    {m[0], m[1], m[2], m[9]} = {str_wr_data0, str_wr_data1, str_wr_data2, frame_pointer_value};
    {m[10], m[11], m[13]} = {argument_pointer_value, psw_switch_value, process_context_block_pointer_switch_value};
    {m[14], m[15]} = {isp_value, pc_target};
    check("cond_flags", {28'h0, cond_flags}, {28'h0, m[11][21:18]});
    check("program_counter_out", program_counter_out, m[15]);
    str_wr_en = 3'h0;
    {frame_pointer_load, argument_pointer_load, process_context_block_pointer_switch_load, isp_load} = 4'h0;
    {psw_switch_load, pc_load} = 2'h0;
    flags_we = 1;
    flags_in = 4'(rnd());
    pc_advance = 1;
    pc_length = {28'h0, 4'(rnd())};
    tick();
    m[11][21:18] = flags_in;
    m[15] = m[15] + pc_length;
    check("cond_flags", {28'h0, cond_flags}, {28'h0, flags_in});
    check("program_counter_out", program_counter_out, m[15]);
    {flags_we, pc_advance} = 2'h0;
    rd_all();
    // every noted result must have shown up
    check("read_queue", 32'(qa.size() + qb.size()), 32'h0);
    check("stack_queue", 32'(qsa.size() + qsp.size()), 32'h0);
    finish_test();
  end
endmodule
